// ---- pkg/rdsp_regs.svh ----
// Purpose: constants of the relay driver serial slave
// Assumes: included by its bare name, definitions only
// Notes:   frame layout, chunk size and synchroniser depth
// Function
// - decode only after a non-zero whole multiple of eight clocks
// - chip select rise ending an accepted transfer copies shift register into the input register
// - chip select rise ending an accepted transfer clears diagnosis flags
// - serial input sampled into shift register on falling serial clock
// - new output bit presented after each rising serial clock
// - serial input bits travel most significant bit first
// - input frame is a 16-bit word of control and data
// - output word shifted out most significant bit first
// - output driven only while chip select is low, else released
// - one shift register; bit shifted out appears on output for chaining
// - single transfer is 16 clocks, accepted on chip select rise
// - serial clock and input ignored while chip select is high
// - chip select fall loads diagnosis word into shift register
// - command bits 15:14, address bits 10:8, data bits 7:0
// - read answer returns during the following frame
`ifndef RDSP_REGS_SVH
`define RDSP_REGS_SVH
`define RDSP_FRAME_BITS 16
`define RDSP_CHUNK_BITS 8
`define RDSP_CMD_MSB 15
`define RDSP_CMD_LSB 14
`define RDSP_ADDR_MSB 10
`define RDSP_ADDR_LSB 8
`define RDSP_DATA_MSB 7
`define RDSP_DATA_LSB 0
`define RDSP_SYNC_STAGES 2
`define RDSP_WORD_RESET 16'h0000
`endif

// ---- pkg/rdsp_pkg.sv ----
// Purpose: types of the relay driver serial slave
// Assumes: nothing
// Notes:   constants live in rdsp_regs.svh
package rdsp_pkg;
    typedef enum logic {
        RDSP_IDLE,
        RDSP_ACTIVE
    } rdsp_state_e;
    typedef logic [15:0] rdsp_word_t;
endpackage

// ---- hdl/rdsp_sync.sv ----
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to clk
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
`include "rdsp_regs.svh"
module rdsp_sync #(
    parameter int WIDTH = 3,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    if (WIDTH < 1) begin : g_bad_width
        $error("rdsp_sync: WIDTH must be positive");
    end

    // each bit resets to its pin's idle level, so no false edge follows
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    stage1[i] <= RESET_VALUE[i];
                    stage2[i] <= RESET_VALUE[i];
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate

    assign sync_out = stage2;
endmodule // rdsp_sync

// ---- hdl/rdsp_slave.sv ----
// Purpose: serial slave of an eight-channel low-side switch
// Assumes: serial pins sampled by clk (200 MHz); serial clock <= 20.8 MHz (48 ns period)
// Notes:   core supplies diag_word; core consumes cmd_word on cmd_valid
`timescale 1ns/10ps
`include "rdsp_regs.svh"
module rdsp_slave #(
    parameter int FRAME_BITS = `RDSP_FRAME_BITS,
    parameter int CHUNK_BITS = `RDSP_CHUNK_BITS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic si,
    output logic so,
    output logic so_oe,
    input wire logic [FRAME_BITS-1:0] diag_word,
    output logic [FRAME_BITS-1:0] cmd_word,
    output logic [1:0] cmd_code,
    output logic [2:0] cmd_addr,
    output logic [7:0] cmd_data,
    output logic cmd_valid,
    output logic diag_clear
);
    // field slices and bit counter assume the fixed frame layout
    if (FRAME_BITS != 16 || CHUNK_BITS != 8) begin : g_bad_layout
        $error("rdsp_slave: frame layout needs 16 and 8");
    end

    // ----------------------------------------------------------------
    // pin synchronisers and edge finding
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic cs_s, sclk_s, si_s;
    logic cs_q, sclk_q;
    logic cs_fall, cs_rise, sclk_fall, sclk_rise;

    // chip select idles high, serial clock and data idle low
    rdsp_sync #(.WIDTH(3), .RESET_VALUE(3'h4)) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in({cs_n, sclk, si}),
        .sync_out(pins_s)
    );
    assign cs_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign si_s = pins_s[0];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
        end else begin
            cs_q <= cs_s;
            sclk_q <= sclk_s;
        end
    end

    // serial clock is low around chip select edges, so no false edge
    assign cs_fall = cs_q & ~cs_s;
    assign cs_rise = ~cs_q & cs_s;
    assign sclk_fall = sclk_q & ~sclk_s;
    assign sclk_rise = ~sclk_q & sclk_s;

    // ----------------------------------------------------------------
    // frame state
    // ----------------------------------------------------------------
    rdsp_pkg::rdsp_state_e state, next_state;
    rdsp_pkg::rdsp_word_t shreg, next_shreg;
    rdsp_pkg::rdsp_word_t next_cmd_word;
    logic [2:0] bit_mod, next_bit_mod;
    logic seen, next_seen;
    logic next_so, next_so_oe, next_cmd_valid, next_diag_clear;
    logic accept;

    // whole multiple of eight, and at least one clock
    assign accept = (bit_mod == 3'h0) && seen;

    always_comb begin
        next_state = state;
        next_shreg = shreg;
        next_bit_mod = bit_mod;
        next_seen = seen;
        next_so = so;
        next_so_oe = so_oe;
        next_cmd_word = cmd_word;
        next_cmd_valid = 1'b0;
        next_diag_clear = 1'b0;
        unique case (state)
            rdsp_pkg::RDSP_IDLE: begin
                // clock and data ignored while deselected
                if (cs_fall) begin
                    next_state = rdsp_pkg::RDSP_ACTIVE;
                    next_shreg = diag_word;
                    next_so = diag_word[FRAME_BITS-1];
                    next_so_oe = 1'b1;
                    next_bit_mod = 3'h0;
                    next_seen = 1'b0;
                end
            end
            rdsp_pkg::RDSP_ACTIVE: begin
                if (cs_rise) begin
                    next_state = rdsp_pkg::RDSP_IDLE;
                    next_so_oe = 1'b0;
                    if (accept) begin
                        // handed to the core only now
                        next_cmd_word = shreg;
                        next_cmd_valid = 1'b1;
                        next_diag_clear = 1'b1;
                    end
                end else if (sclk_fall) begin
                    // msb first in, chained through the same register
                    next_shreg = {shreg[FRAME_BITS-2:0], si_s};
                    next_bit_mod = bit_mod + 3'h1;
                    next_seen = 1'b1;
                end else if (sclk_rise) begin
                    next_so = shreg[FRAME_BITS-1];
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= rdsp_pkg::RDSP_IDLE;
            shreg <= `RDSP_WORD_RESET;
            bit_mod <= 3'h0;
            seen <= 1'b0;
            so <= 1'b0;
            so_oe <= 1'b0;
            cmd_word <= `RDSP_WORD_RESET;
            cmd_valid <= 1'b0;
            diag_clear <= 1'b0;
        end else begin
            state <= next_state;
            shreg <= next_shreg;
            bit_mod <= next_bit_mod;
            seen <= next_seen;
            so <= next_so;
            so_oe <= next_so_oe;
            cmd_word <= next_cmd_word;
            cmd_valid <= next_cmd_valid;
            diag_clear <= next_diag_clear;
        end
    end

    // field slices of the accepted word; read answer is core's job
    assign cmd_code = cmd_word[`RDSP_CMD_MSB:`RDSP_CMD_LSB];
    assign cmd_addr = cmd_word[`RDSP_ADDR_MSB:`RDSP_ADDR_LSB];
    assign cmd_data = cmd_word[`RDSP_DATA_MSB:`RDSP_DATA_LSB];

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_accept_multiple: assert property (@(posedge clk)
        disable iff (reset)
        cmd_valid |-> $past(bit_mod) == 3'h0 && $past(seen) && $past(cs_rise))
        else $error("command taken after a partial byte");

    a_reject_partial: assert property (@(posedge clk)
        disable iff (reset)
        cs_rise && state == rdsp_pkg::RDSP_ACTIVE && !accept |=> !cmd_valid)
        else $error("partial frame was not discarded");

    a_word_copy: assert property (@(posedge clk) disable iff (reset)
        cs_rise && state == rdsp_pkg::RDSP_ACTIVE && accept
        |=> cmd_valid && cmd_word == $past(shreg))
        else $error("accepted word differs from shift register");

    a_diag_clear_pair: assert property (@(posedge clk)
        disable iff (reset)
        cmd_valid == diag_clear)
        else $error("diagnosis clear not paired with acceptance");

    a_shift_in_msb: assert property (@(posedge clk) disable iff (reset)
        sclk_fall && !cs_rise && state == rdsp_pkg::RDSP_ACTIVE
        |=> shreg[0] == $past(si_s)
            && shreg[FRAME_BITS-1:1] == $past(shreg[FRAME_BITS-2:0]))
        else $error("serial input not shifted in msb first");

    a_out_on_rise: assert property (@(posedge clk) disable iff (reset)
        sclk_rise && !cs_rise && state == rdsp_pkg::RDSP_ACTIVE
        |=> so == $past(shreg[FRAME_BITS-1]))
        else $error("output bit not presented after rising clock");

    a_oe_released: assert property (@(posedge clk) disable iff (reset)
        cs_s && $past(cs_s) |-> !so_oe)
        else $error("output driven while deselected");

    a_idle_ignore: assert property (@(posedge clk) disable iff (reset)
        state == rdsp_pkg::RDSP_IDLE && !cs_fall
        |=> $stable(shreg) && !so_oe)
        else $error("activity accepted while deselected");

    a_load_diag: assert property (@(posedge clk) disable iff (reset)
        state == rdsp_pkg::RDSP_IDLE && cs_fall
        |=> shreg == $past(diag_word) && so == $past(diag_word[15]) && so_oe)
        else $error("diagnosis word not loaded on select");
endmodule // rdsp_slave

// ---- verification/rdsp_master_model.sv ----
// Purpose: behavioural host master for the relay driver serial link
// Assumes: serial clock timed free of clk; chip select moves on clk edges
// Notes:   si idles low as its pin pull-down would leave it
`timescale 1ns/10ps
module rdsp_master_model #(
    parameter int HALF_NS = 24,
    parameter int HOLD_NS = 12,
    parameter int GAP_NS = 250
) (
    input wire logic clk,
    input wire logic so_w,
    output logic cs_n,
    output logic sclk,
    output logic si
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end

    // --------------------------------------------------------------
    // one frame of n clocks; so read as each falling edge is driven
    // --------------------------------------------------------------
    // half-ns skew keeps serial edges off clk edges: no sampling races
    task automatic xfer(input int n, input logic [63:0] tx,
                        output logic [63:0] rx);
        rx = '0;
        @(posedge clk);
        cs_n <= 1'b0; // sclk is low here
        si <= (n > 0) ? tx[n-1] : 1'b0; // msb first
        #0.5;
        #(GAP_NS);
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b1;
            #(HALF_NS);
            rx[i] = so_w;
            sclk = 1'b0;
            // si held past the fall so the slave takes the old bit
            #(HOLD_NS);
            si = (i > 0) ? tx[i-1] : 1'b0;
            #(HALF_NS - HOLD_NS);
        end
        #(GAP_NS);
        @(posedge clk);
        cs_n <= 1'b1; // after n clocks
        #(GAP_NS);
        #0.5;
    endtask

    // clocks while deselected, which the slave must ignore
    task automatic idle_clocks(input int n);
        for (int k = 0; k < n; k++) begin
            si = k[0];
            sclk = 1'b1;
            #(HALF_NS);
            sclk = 1'b0;
            #(HALF_NS);
        end
        si = 1'b0;
    endtask
endmodule // rdsp_master_model

// ---- verification/tb_top.sv ----
// Purpose: self-checking bench of the relay driver serial slave
// Assumes: master model drives the link pins
// Notes:   so is resolved to z whenever so_oe is low
`timescale 1ns/10ps
module tb_top;
    logic clk, reset, cs_n, sclk, si, so, so_oe, cmd_valid, diag_clear;
    logic [15:0] diag_word, cmd_word;
    logic [1:0] cmd_code;
    logic [2:0] cmd_addr;
    logic [7:0] cmd_data;
    logic [63:0] rx;
    wire so_w;
    int n_errors = 0, samples_checked = 0, n_valid = 0, base;
    assign so_w = so_oe ? so : 1'bz;

    rdsp_slave uut (.clk(clk), .reset(reset), .cs_n(cs_n), .sclk(sclk),
        .si(si), .so(so), .so_oe(so_oe), .diag_word(diag_word),
        .cmd_word(cmd_word), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .cmd_data(cmd_data), .cmd_valid(cmd_valid),
        .diag_clear(diag_clear));
    rdsp_master_model #(.HALF_NS(24)) m (.clk(clk), .so_w(so_w),
        .cs_n(cs_n), .sclk(sclk), .si(si));

    // --------------------------------------------------------------
    // clock, pulse monitor, helpers
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (cmd_valid === 1'b1)
            n_valid <= n_valid + 1;
        if (cmd_valid !== diag_clear) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, diag_clear, cmd_valid);
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("errors=%0d checks=%0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic t_frame(input logic [15:0] tx, input logic [15:0] d);
        @(posedge clk) diag_word <= d;
        base = n_valid;
        m.xfer(16, {48'h0, tx}, rx);
        chk(rx[15:0], {48'h0, d});
        chk(cmd_word, tx);
        chk({cmd_code, cmd_addr, cmd_data}, {tx[15:14], tx[10:0]});
        chk(n_valid - base, 1);
        chk(so_w, 1'bz);
    endtask
    task automatic t_discard(input int n);
        base = n_valid;
        m.xfer(n, 64'hfedc_ba98_7654_3210, rx);
        chk(cmd_word, 16'h4201);
        chk(n_valid - base, 0);
    endtask
    task automatic t_chain();
        @(posedge clk) diag_word <= 16'h9e37;
        base = n_valid;
        m.xfer(32, {32'h0, 16'h1234, 16'hc0de}, rx);
        chk(rx[31:16], 16'h9e37);
        chk(rx[15:0], 16'h1234);
        chk(cmd_word, 16'hc0de);
        m.xfer(24, {40'h0, 24'h5a_6b7c}, rx);
        chk(cmd_word, 16'h6b7c);
        chk(n_valid - base, 2);
    endtask
    task automatic t_idle();
        base = n_valid;
        m.idle_clocks(16);
        chk(n_valid - base, 0);
        chk(cmd_word, 16'h6b7c);
        chk(so_w, 1'bz);
    endtask

    initial begin
        reset = 1'b1;
        diag_word = 16'h0000;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        repeat (5) @(posedge clk);
        chk({so_oe, cmd_valid, cmd_word}, 18'h0);
        t_frame(16'ha5c3, 16'h3c96);
        t_frame(16'h4201, 16'h4255);
        t_discard(0);
        t_discard(12);
        t_discard(7);
        t_chain();
        t_idle();
        end_sim();
    end
    initial begin
        #200us;
        n_errors++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim();
    end
endmodule // tb_top
